// ---- core/flash_host_regs.svh ----
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// ----------------------------------------------------------------------
// Clock and pulse timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    4
`define PROG_PULSE_NS    10000
`define PROG_PULSE_CYC   ((`PROG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_PULSE_NS   10000000
`define ERASE_PULSE_CYC  ((`ERASE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VPP_SETTLE_NS    1000
`define VPP_SETTLE_CYC   ((`VPP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS        100
`define STROBE_CYC       ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_NS          150
`define READ_CYC         ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Flow limits
// ----------------------------------------------------------------------
`define MAX_PROG_PULSES  25
`define ERASE_RETRY_MAX  1000

// ----------------------------------------------------------------------
// Command codes and data patterns
// ----------------------------------------------------------------------
`define CMD_READ         8'h00
`define CMD_ERASE        8'h20
`define CMD_PROG_SETUP   8'h40
`define CMD_ERASE_VERIFY 8'hA0
`define CMD_PROG_VERIFY  8'hC0
`define ERASED_BYTE      8'hFF
`define PREPROG_BYTE     8'h00

`endif

// ---- core/flash_host_pkg.sv ----
package flash_host_pkg;

  typedef enum logic [1:0] {EG_IDLE, EG_SETUP, EG_STROBE, EG_HOLD} eng_state_t;

  typedef enum logic [1:0] {PH_PROG, PH_SCAN, PH_PREPROG, PH_ERASE} phase_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_VPP_ON, ST_SCAN_RD, ST_P_SETUP, ST_P_DATA, ST_P_PULSE,
    ST_P_VCMD, ST_P_READ, ST_E_SETUP, ST_E_GO, ST_E_PULSE, ST_E_VCMD,
    ST_E_READ, ST_FIN_CMD, ST_VPP_OFF, ST_DONE
  } flow_state_t;

endpackage

// ---- core/flash_cycle_if.sv ----
`timescale 1ns/100ps
interface flash_cycle_if #(
  parameter int ADDR_W = 18,
  parameter int CHIP_W = 1
);
  logic              req;
  logic              write;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [CHIP_W-1:0] chip;
  logic              ack;
  logic [7:0]        rdata;

  modport ctrl (output req, write, addr, wdata, chip, input ack, rdata);
  modport eng  (input req, write, addr, wdata, chip, output ack, rdata);
endinterface

// ---- core/pulse_timer.sv ----
`timescale 1ns/100ps
module pulse_timer #(
  parameter int W = 24
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  // A length of zero would wrap, so callers always load at least one cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        cnt_q <= len - W'(1);
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

  assign done = run_q && (cnt_q == '0);
endmodule // pulse_timer

// ---- core/flash_bus_engine.sv ----
`timescale 1ns/100ps
`include "flash_host_regs.svh"
module flash_bus_engine
  import flash_host_pkg::*;
#(
  parameter int NUM_CHIPS = 1,
  parameter int ADDR_W    = 18,
  parameter int CHIP_W    = 1
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic          supply_ok,
  flash_cycle_if.eng         cyc,
  input  wire logic [7:0]    flash_dq_in,
  output logic [NUM_CHIPS-1:0] flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [ADDR_W-1:0]  flash_addr,
  output logic [7:0]         flash_dq_out,
  output logic               flash_dq_oe
);
  eng_state_t state_q;
  logic [7:0] cnt_q;
  logic       wr_q;
  logic       start;
  logic [7:0] last_cnt;

  // ----------------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------------
  // No new cycle starts while the supply is not stable; a cycle already started still strobes.
  assign start    = (state_q == EG_IDLE) && cyc.req && !cyc.ack && supply_ok;
  assign last_cnt = wr_q ? 8'(`STROBE_CYC - 1) : 8'(`READ_CYC - 1);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= EG_IDLE;
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
      cyc.ack <= 1'b0;
      cyc.rdata <= 8'h00;
    end else if (clk_en) begin
      cyc.ack <= 1'b0;
      unique case (state_q)
        EG_IDLE: if (start) begin
          state_q <= EG_SETUP;
          wr_q    <= cyc.write;
        end
        EG_SETUP: begin
          state_q <= EG_STROBE;
          cnt_q   <= 8'h00;
        end
        EG_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == last_cnt) begin
            state_q <= EG_HOLD;
            if (!wr_q) cyc.rdata <= flash_dq_in;
          end
        end
        EG_HOLD: begin
          state_q <= EG_IDLE;
          cyc.ack <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // Address and data are held for the whole cycle, so the device latches
  // the address on the falling strobe and the data on the rising one.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_addr   <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe  <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        flash_addr   <= cyc.addr;
        flash_dq_out <= cyc.wdata;
        flash_dq_oe  <= cyc.write;
      end else if (state_q == EG_SETUP) begin
        flash_we_n <= !wr_q;
        flash_oe_n <= wr_q;
      end else if (state_q == EG_STROBE && cnt_q == last_cnt) begin
        flash_we_n <= 1'b1;
        flash_oe_n <= 1'b1;
      end else if (state_q == EG_HOLD) begin
        flash_dq_oe <= 1'b0;
      end
    end
  end

  // Each chip select is decoded from the chip index; the read strobe is shared.
  for (genvar i = 0; i < NUM_CHIPS; i++) begin : g_ce
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        flash_ce_n[i] <= 1'b1;
      end else if (clk_en) begin
        if (start) begin
          flash_ce_n[i] <= (cyc.chip != CHIP_W'(i));
        end else if (state_q == EG_HOLD) begin
          flash_ce_n[i] <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  chk_one_chip_select: assert property ($onehot0(~flash_ce_n))
    else $error("more than one chip selected");
  chk_strobe_in_select: assert property (!flash_we_n |-> !(&flash_ce_n) && flash_oe_n)
    else $error("write strobe without chip select");
endmodule // flash_bus_engine

// ---- core/flash_host_ctrl.sv ----
// Functional notes
// - Each program pulse lasts ten microseconds.
// - Verify the byte after every program pulse.
// - At most 25 pulses per byte.
// - Program supply stays on through each loop.
// - Preprogram every byte to zero before erase.
// - Scan first; all-erased part skips erasure.
// - Issue first erase after preprogramming ends.
// - Erase verify from zero until fail or end.
// - Resume erase verify from the failed address.
// - Program verify only after a program pulse.
// - Erase verify only after an erase pulse.
// - No strobes while supply is unstable; only new bus cycles are held off, one already started completes.
// - Decode chip selects, share the read strobe.
// - Program setup code, then address and data write.
// - Program verify code ends the pulse.
// - Erase code twice starts the erase pulse.
// - Erase verify code with address ends erase.
`timescale 1ns/100ps
`include "flash_host_regs.svh"
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int NUM_CHIPS       = 1,
  parameter int ADDR_W          = 18,
  parameter int TMR_W           = 24,
  parameter int ERASE_PULSE_CYC = `ERASE_PULSE_CYC,
  parameter int ERASE_RETRY_MAX = `ERASE_RETRY_MAX,
  localparam int CHIP_W         = (NUM_CHIPS > 1) ? $clog2(NUM_CHIPS) : 1
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 cmd_start,
  input  wire logic                 cmd_erase,
  input  wire logic [CHIP_W-1:0]    cmd_chip,
  input  wire logic [ADDR_W-1:0]    cmd_addr,
  input  wire logic [7:0]           cmd_data,
  input  wire logic                 supply_ok,
  input  wire logic [7:0]           flash_dq_in,
  output logic                      busy,
  output logic                      done,
  output logic                      fail,
  output logic [ADDR_W-1:0]         fail_addr,
  output logic                      vpp_en,
  output logic [NUM_CHIPS-1:0]      flash_ce_n,
  output logic                      flash_oe_n,
  output logic                      flash_we_n,
  output logic [ADDR_W-1:0]         flash_addr,
  output logic [7:0]                flash_dq_out,
  output logic                      flash_dq_oe
);
  localparam int PROG_CYC  = `PROG_PULSE_CYC;
  localparam int MAX_PULSE = `MAX_PROG_PULSES;

  flow_state_t       state_q, state_d;
  phase_t            phase_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        data_q;
  logic [CHIP_W-1:0] chip_q;
  logic [4:0]        pulse_cnt_q;
  logic [15:0]       erase_cnt_q;
  logic              req_q;
  logic              bus_state;
  logic              last_addr;
  logic              tmr_start;
  logic              tmr_done;
  logic [TMR_W-1:0]  tmr_len;
  logic [7:0]        target;
  logic              rd_match;
  logic              give_up;
  logic [15:0]       pulse_len_q;
  logic [7:0]        last_cmd_q;

  flash_cycle_if #(.ADDR_W(ADDR_W), .CHIP_W(CHIP_W)) cyc ();

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  flash_bus_engine #(
    .NUM_CHIPS (NUM_CHIPS),
    .ADDR_W    (ADDR_W),
    .CHIP_W    (CHIP_W)
  ) u_engine (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .clk_en       (clk_en),
    .supply_ok    (supply_ok),
    .cyc          (cyc.eng),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe)
  );

  // The device has no clock, so every pulse is counted here.
  pulse_timer #(.W(TMR_W)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .start   (tmr_start),
    .len     (tmr_len),
    .done    (tmr_done)
  );

  // ----------------------------------------------------------------------
  // Flow sequencing
  // ----------------------------------------------------------------------
  assign last_addr = &addr_q;
  assign target    = (phase_q == PH_PREPROG) ? `PREPROG_BYTE : data_q;
  assign rd_match  = (cyc.rdata == target);
  assign give_up   = (pulse_cnt_q == 5'(MAX_PULSE));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:    if (cmd_start && supply_ok) state_d = ST_VPP_ON;
      ST_VPP_ON:  if (tmr_done) state_d = (phase_q == PH_SCAN) ? ST_SCAN_RD : ST_P_SETUP;
      ST_SCAN_RD: if (cyc.ack) begin
        if (cyc.rdata != `ERASED_BYTE) state_d = ST_P_SETUP;
        else if (last_addr) state_d = ST_FIN_CMD;
      end
      ST_P_SETUP: if (cyc.ack) state_d = ST_P_DATA;
      ST_P_DATA:  if (cyc.ack) state_d = ST_P_PULSE;
      ST_P_PULSE: if (tmr_done) state_d = ST_P_VCMD;
      ST_P_VCMD:  if (cyc.ack) state_d = ST_P_READ;
      ST_P_READ:  if (cyc.ack) begin
        if (!rd_match) state_d = give_up ? ST_FIN_CMD : ST_P_SETUP;
        else if (phase_q != PH_PREPROG) state_d = ST_FIN_CMD;
        else state_d = last_addr ? ST_E_SETUP : ST_P_SETUP;
      end
      ST_E_SETUP: if (cyc.ack) state_d = ST_E_GO;
      ST_E_GO:    if (cyc.ack) state_d = ST_E_PULSE;
      ST_E_PULSE: if (tmr_done) state_d = ST_E_VCMD;
      ST_E_VCMD:  if (cyc.ack) state_d = ST_E_READ;
      ST_E_READ:  if (cyc.ack) begin
        if (cyc.rdata == `ERASED_BYTE) state_d = last_addr ? ST_FIN_CMD : ST_E_VCMD;
        else if (erase_cnt_q == 16'(ERASE_RETRY_MAX - 1)) state_d = ST_FIN_CMD;
        else state_d = ST_E_SETUP;
      end
      ST_FIN_CMD: if (cyc.ack) state_d = ST_VPP_OFF;
      ST_VPP_OFF: if (tmr_done) state_d = ST_DONE;
      ST_DONE:    state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      phase_q <= PH_PROG;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_q == ST_IDLE && state_d == ST_VPP_ON) begin
        phase_q <= cmd_erase ? PH_SCAN : PH_PROG;
      end else if (state_q == ST_SCAN_RD && state_d == ST_P_SETUP) begin
        phase_q <= PH_PREPROG;
      end else if (state_q == ST_P_READ && state_d == ST_E_SETUP) begin
        phase_q <= PH_ERASE;
      end
    end
  end

  // The settle wait and both pulses share one timer; they never overlap.
  assign tmr_start = (state_d != state_q) && (state_d == ST_VPP_ON || state_d == ST_VPP_OFF ||
                     state_d == ST_P_PULSE || state_d == ST_E_PULSE);
  always_comb begin
    if (state_d == ST_P_PULSE) tmr_len = TMR_W'(PROG_CYC);
    else if (state_d == ST_E_PULSE) tmr_len = TMR_W'(ERASE_PULSE_CYC);
    else tmr_len = TMR_W'(`VPP_SETTLE_CYC);
  end

  // ----------------------------------------------------------------------
  // Address, data and retry counters
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_q <= '0;
      data_q <= 8'h00;
      chip_q <= '0;
    end else if (clk_en) begin
      if (state_q == ST_IDLE && state_d == ST_VPP_ON) begin
        addr_q <= cmd_erase ? '0 : cmd_addr;
        data_q <= cmd_data;
        chip_q <= cmd_chip;
      end else if (cyc.ack) begin
        if (state_q == ST_SCAN_RD && cyc.rdata != `ERASED_BYTE) begin
          addr_q <= '0;
        end else if ((state_q == ST_SCAN_RD || state_q == ST_E_READ) &&
                     cyc.rdata == `ERASED_BYTE && !last_addr) begin
          addr_q <= addr_q + ADDR_W'(1);
        end else if (state_q == ST_P_READ && phase_q == PH_PREPROG && rd_match) begin
          addr_q <= addr_q + ADDR_W'(1);
        end
      end
    end
  end

  // Pulses are counted per byte, so the count clears whenever a byte passes.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pulse_cnt_q <= 5'h00;
      erase_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (state_q == ST_IDLE) begin
        pulse_cnt_q <= 5'h00;
        erase_cnt_q <= 16'h0000;
      end else if (state_q == ST_P_DATA && cyc.ack) begin
        pulse_cnt_q <= pulse_cnt_q + 5'h01;
      end else if (state_q == ST_P_READ && cyc.ack && rd_match) begin
        pulse_cnt_q <= 5'h00;
      end else if (state_q == ST_E_READ && cyc.ack && cyc.rdata != `ERASED_BYTE) begin
        erase_cnt_q <= erase_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus cycle requests
  // ----------------------------------------------------------------------
  always_comb begin
    bus_state  = 1'b1;
    cyc.write  = 1'b1;
    cyc.wdata  = `CMD_READ;
    cyc.addr   = addr_q;
    cyc.chip   = chip_q;
    unique case (state_q)
      ST_SCAN_RD, ST_P_READ, ST_E_READ: cyc.write = 1'b0;
      ST_P_SETUP: cyc.wdata = `CMD_PROG_SETUP;
      ST_P_DATA:  cyc.wdata = target;
      ST_P_VCMD:  cyc.wdata = `CMD_PROG_VERIFY;
      ST_E_SETUP, ST_E_GO: cyc.wdata = `CMD_ERASE;
      ST_E_VCMD:  cyc.wdata = `CMD_ERASE_VERIFY;
      ST_FIN_CMD: cyc.wdata = `CMD_READ;
      default:    bus_state = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_q      <= 1'b0;
      last_cmd_q <= `CMD_READ;
    end else if (clk_en) begin
      if (cyc.ack) begin
        req_q <= 1'b0;
        if (cyc.write) last_cmd_q <= cyc.wdata;
      end else if (bus_state) begin
        req_q <= 1'b1;
      end
    end
  end
  assign cyc.req = req_q;

  // ----------------------------------------------------------------------
  // Status and supply outputs
  // ----------------------------------------------------------------------
  // The supply rises before the first command and falls only after read
  // mode is restored, so no pulse or verify ever runs without it.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      fail      <= 1'b0;
      fail_addr <= '0;
      vpp_en    <= 1'b0;
    end else if (clk_en) begin
      busy   <= (state_d != ST_IDLE);
      done   <= (state_d == ST_DONE);
      vpp_en <= !(state_d inside {ST_IDLE, ST_VPP_OFF, ST_DONE});
      if (state_q == ST_IDLE && state_d == ST_VPP_ON) begin
        fail <= 1'b0;
      end else if (state_d == ST_FIN_CMD && state_q inside {ST_P_READ, ST_E_READ} &&
                   cyc.rdata != ((state_q == ST_P_READ) ? target : `ERASED_BYTE)) begin
        fail      <= 1'b1;
        fail_addr <= addr_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pulse_len_q <= 16'h0000;
    end else if (clk_en) begin
      pulse_len_q <= (state_q == ST_P_PULSE) ? pulse_len_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence s_prog_pulse_end;
    state_q == ST_P_PULSE && tmr_done;
  endsequence
  sequence s_verify_write;
    state_q == ST_P_VCMD && cyc.write && cyc.wdata == `CMD_PROG_VERIFY;
  endsequence

  chk_prog_pulse_len: assert property (s_prog_pulse_end |-> pulse_len_q == 16'(PROG_CYC - 1))
    else $error("program pulse length wrong");
  chk_verify_follows: assert property (s_prog_pulse_end |=> s_verify_write)
    else $error("no verify after program pulse");
  chk_pulse_limit: assert property (pulse_cnt_q <= 5'(MAX_PULSE))
    else $error("too many program pulses");
  chk_vpp_held: assert property (state_q inside {[ST_P_SETUP:ST_E_READ]} |-> vpp_en)
    else $error("program supply off during loop");
  chk_preprog_zero: assert property (phase_q == PH_PREPROG && state_q == ST_P_DATA
                                     |-> cyc.wdata == `PREPROG_BYTE)
    else $error("preprogram data not zero");
  chk_erase_after_pre: assert property (state_q == ST_P_READ && state_d == ST_E_SETUP
                                        |-> phase_q == PH_PREPROG && last_addr)
    else $error("erase before preprogram done");
  chk_erase_resume: assert property (state_q == ST_E_READ && state_d == ST_E_SETUP
                                     |=> addr_q == $past(addr_q))
    else $error("erase verify does not resume");
  chk_start_lockout: assert property (state_q == ST_IDLE && !supply_ok |=> state_q == ST_IDLE)
    else $error("flow started with unstable supply");
  chk_done_read_mode: assert property (state_q == ST_DONE |-> last_cmd_q == `CMD_READ && !vpp_en)
    else $error("flow ended outside read mode");
endmodule // flash_host_ctrl

// ---- tb/flash_dev_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Behavioural memory device with a slow, tunable cell response.
// ----------------------------------------------------------------------
module flash_dev_model #(
  parameter int AW = 3
) (
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic          vpp,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    din,
  output logic [7:0]         q
);
  logic [7:0]    mem [2**AW];
  logic [7:0]    mode, pd, rdv, last_q;
  logic [AW-1:0] la, pa, va;
  logic          arm_p, arm_e, prog_on, erase_on, ep;
  int            pc, ec, n_ev, n_bad, prog_need, erase_step;
  realtime       t0;
  initial begin
    mode = 8'h00;
    {arm_p, arm_e, prog_on, erase_on, ep, last_q, la, pa, va} = '0;
    {pc, ec, n_ev, n_bad} = '0;
    prog_need = 1;
    erase_step = 2**AW;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) begin
    ep = prog_on;
    if (prog_on) begin
      prog_on = 1'b0;
      pc++;
      if ($realtime - t0 < 10000.0) n_bad++;
      if (pc == prog_need) mem[pa] = mem[pa] & pd;
    end
    if (erase_on) begin
      erase_on = 1'b0;
      ec++;
      foreach (mem[i]) if (i < ec * erase_step) mem[i] = 8'hFF;
    end
    if (arm_p) begin
      if (la != pa) pc = 0;
      pa = la;
      pd = din;
      prog_on = 1'b1;
      t0 = $realtime;
      arm_p = 1'b0;
      if (!vpp || pc >= 25) n_bad++;
    end else if (arm_e && din == 8'h20) begin
      if (ec == 0) foreach (mem[i]) if (mem[i] !== 8'h00) n_bad++;
      if (!vpp) n_bad++;
      erase_on = 1'b1;
      arm_e = 1'b0;
    end else begin
      arm_p = (din == 8'h40);
      arm_e = (din == 8'h20);
      mode = din;
      if (din == 8'hC0 && !ep) n_bad++;
      if (din == 8'hA0) begin
        va = la;
        n_ev++;
        if (ec == 0) n_bad++;
      end
    end
  end
  // A deselected device floats its bus, so show a changed value, never the last one.
  assign rdv = (mode == 8'hC0) ? mem[pa] : (mode == 8'hA0) ? mem[va] : mem[addr];
  always @* if (!ce_n && !oe_n) last_q = rdv;
  assign q = (!ce_n && !oe_n) ? rdv : ~last_q;
endmodule // flash_dev_model

// ---- tb/test_flash_pulse_program_erase_flow.sv ----
`timescale 1ns/100ps
module test_flash_pulse_program_erase_flow;
  typedef struct {
    logic er; logic [2:0] a; logic [7:0] d; int need; logic [7:0] exp; int pulses;
  } row_t;
  logic       ref_clk, rst_n, cmd_start, cmd_erase, supply_ok, busy, done, fail;
  logic       vpp_en, oe_n, we_n, dq_oe, clk_en;
  logic [0:0] ce_n;
  logic [2:0] cmd_addr, fail_addr, addr;
  logic [7:0] cmd_data, dq_in, dq_out;
  int         mismatches, n_tests;
  row_t       rows[3] = '{'{1'b1, 3'd0, 8'h00, 1, 8'hFF, 0},
                          '{1'b0, 3'd3, 8'h5A, 2, 8'h5A, 2},
                          '{1'b0, 3'd6, 8'h00, 1, 8'h00, 1}};

  flash_host_ctrl #(.ADDR_W(3), .ERASE_PULSE_CYC(50), .ERASE_RETRY_MAX(20)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_start(cmd_start),
    .cmd_erase(cmd_erase), .cmd_chip(1'b0), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .supply_ok(supply_ok), .flash_dq_in(dq_in), .busy(busy), .done(done), .fail(fail),
    .fail_addr(fail_addr), .vpp_en(vpp_en), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
  flash_dev_model #(.AW(3)) dev (.ce_n(ce_n[0]), .oe_n(oe_n), .we_n(we_n), .vpp(vpp_en),
    .addr(addr), .din(dq_out), .q(dq_in));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(logic er, logic [2:0] a, logic [7:0] d);
    int k;
    @(posedge ref_clk);
    cmd_erase <= er;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_start <= 1'b1;
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    for (k = 0; k < 80000 && done !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    check("done", 1, done);
    @(posedge ref_clk);
    #1;
    check("busy", 0, busy);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // The full run is about 99k cycles, so the limit leaves a small margin.
  initial begin
    repeat (104000) @(posedge ref_clk);
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    {rst_n, cmd_start, cmd_erase, cmd_addr, cmd_data} = '0;
    supply_ok = 1'b1;
    clk_en = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("vpp_en", 0, vpp_en);
    check("we_n", 1, we_n);
    check("ce_n", 1, ce_n);
    check("dq_oe", 0, dq_oe);
    check("oe_n", 1, oe_n);
    check("addr", 0, addr);
    check("dq_out", 0, dq_out);
    check("busy", 0, busy);
    check("fail", 0, fail);
    $display("test reset done");
    foreach (rows[i]) begin
      dev.prog_need = rows[i].need;
      run(rows[i].er, rows[i].a, rows[i].d);
      check("fail", 0, fail);
      check("pulses", rows[i].pulses, dev.pc);
      check("byte", rows[i].exp, dev.mem[rows[i].a]);
      check("erases", 0, dev.ec);
      $display("test row %0d done", i);
    end
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    cmd_start <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    check("busy", 0, busy);
    check("vpp_en", 0, vpp_en);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    clk_en <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    check("busy", 0, busy);
    check("done", 0, done);
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    clk_en <= 1'b1;
    @(posedge ref_clk);
    $display("test refusal done");
    dev.prog_need = 1;
    dev.erase_step = 3;
    run(1'b1, 3'd0, 8'h00);
    check("fail", 0, fail);
    check("erases", 3, dev.ec);
    check("verifies", 10, dev.n_ev);
    foreach (dev.mem[i]) check("erased", 8'hFF, dev.mem[i]);
    $display("test erase done");
    dev.prog_need = 99;
    run(1'b0, 3'd2, 8'h00);
    check("fail", 1, fail);
    check("fail_addr", 2, fail_addr);
    check("pulses", 25, dev.pc);
    check("mode", 8'h00, dev.mode);
    check("vpp_en", 0, vpp_en);
    check("faults", 0, dev.n_bad);
    $display("test pulse limit done");
    stop_test();
  end
endmodule // test_flash_pulse_program_erase_flow
